// ### src/cgt_pkg.sv
// cgt_pkg: shared constants and types of the carrier generator timer
package cgt_pkg;

  // data and address widths of the register port
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 3;

  // register offsets on the plain register port
  localparam logic [ADDR_W-1:0] ADDR_RUN_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_FIRST_CMP = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_SECOND_CMP = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_CARRIER_CTRL = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 3'h6;

  // field positions
  localparam int unsigned RUN_BIT = 0;
  localparam int unsigned GATE_FLAG_BIT = 0;
  localparam int unsigned GATE_BUF_BIT = 1;
  localparam int unsigned REMOTE_SEL_BIT = 2;
  localparam int unsigned IRQ_MATCH_BIT = 0;

  // values after reset
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] CNT_CLEAR = 8'h00;

  // stages of the pin-input synchroniser
  localparam int unsigned SYNC_STAGES = 3;

  // which compare register the counter is matched against
  typedef enum logic {
    CMP_FIRST,
    CMP_SECOND
  } cgt_cmp_sel_t;

endpackage

// ### src/cgt_sync_if.sv
// cgt_sync_if: carries the raw companion match and its synchronised event
`timescale 1ns/100ps
interface cgt_sync_if;
  logic raw_match; // match level from the companion timer domain
  logic gate_evt; // one-cycle event on the count clock
  modport sync (input raw_match, output gate_evt);
  modport user (output raw_match, input gate_evt);
endinterface

// ### src/cgt_sync.sv
// cgt_sync: three-stage synchroniser and edge detector for the companion match
`timescale 1ns/100ps
module cgt_sync #(
  parameter int unsigned STAGES = cgt_pkg::SYNC_STAGES
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // synchronised event path
  cgt_sync_if.sync sif
);

  // the agreement test below reads the second and third stage only,
  // so any other depth is refused while the design is elaborated
  if (STAGES != 3) begin : g_bad_stages
    $error("cgt_sync supports exactly three stages");
  end

  logic [STAGES-1:0] sh_q; // shift chain, stage 0 first
  logic [STAGES-1:0] sh_d;
  logic lvl_q; // accepted level
  logic lvl_d;
  logic evt_q; // registered rising event
  logic evt_d;

  // next values: a change counts once stages two and three agree
  always_comb begin
    sh_d = {sh_q[STAGES-2:0], sif.raw_match};
    lvl_d = lvl_q;
    if (sh_q[1] == sh_q[2]) begin
      lvl_d = sh_q[2];
    end
    evt_d = lvl_d & ~lvl_q;
  end

  // registers only
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sh_q <= '0;
      lvl_q <= 1'b0;
      evt_q <= 1'b0;
    end else begin
      sh_q <= sh_d;
      lvl_q <= lvl_d;
      evt_q <= evt_d;
    end
  end

  assign sif.gate_evt = evt_q;

endmodule

// ### src/cgt_top.sv
// cgt_top: carrier generator timer with gated carrier output and register port
//
// Contract
// R1: counter stays stopped while both run bits clear
// R2: run bit starts counting, carrier at default
// R3: first compare match: irq, invert, switch, clear
// R4: second compare match: irq, invert, switch back, clear
// R5: alternation repeats, duty set by two compares
// R6: companion match synchronised into gating event
// R7: gate set: carrier appears at first rising edge
// R8: gate cleared while high: hold until carrier falls
// R9: gating event is internal, never an interrupt
// R10: select 00/10 low, 01 high, 11 carrier pulses
// R11: gate flag read-only, low disabled, high enabled
// R12: second compare write while counting latched until match
// R13: second compare write colliding with match is dropped
// R14: stopping returns to first compare, clears counter
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module cgt_top (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // register port
  input wire logic [cgt_pkg::ADDR_W-1:0] i_addr,
  input wire logic [cgt_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [cgt_pkg::DATA_W-1:0] o_rdata,
  // companion event timer
  input wire logic i_event_timer_run,
  input wire logic i_event_timer_match,
  // carrier pin and interrupts
  output logic o_carrier_output_pin,
  output logic o_carrier_match_irq,
  output logic o_irq
);

  localparam int unsigned DW = cgt_pkg::DATA_W;

  // write decode, used for every writable register
  function automatic logic wr_hit(input logic [cgt_pkg::ADDR_W-1:0] a);
    wr_hit = i_wr && (i_addr == a);
  endfunction

  // ---------------------------------------------------------------
  // synchronised gating event from the companion timer
  // ---------------------------------------------------------------
  cgt_sync_if sif ();
  assign sif.raw_match = i_event_timer_match;

  cgt_sync #(
    .STAGES(cgt_pkg::SYNC_STAGES)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .sif(sif)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic run_q; // carrier timer run bit
  logic run_d;
  logic [DW-1:0] first_q; // first compare value
  logic [DW-1:0] first_d;
  logic [DW-1:0] second_q; // second compare value in use
  logic [DW-1:0] second_d;
  logic [DW-1:0] pend_val_q; // second compare value waiting for a match
  logic [DW-1:0] pend_val_d;
  logic pend_q; // a latched second compare write is waiting
  logic pend_d;
  logic [DW-1:0] cnt_q; // carrier counter
  logic [DW-1:0] cnt_d;
  cgt_pkg::cgt_cmp_sel_t phase_q; // compare currently matched against
  cgt_pkg::cgt_cmp_sel_t phase_d;
  logic carrier_q; // internal carrier clock
  logic carrier_d;
  logic match; // counter equals the active compare while the run bit is set
  logic [DW-1:0] cmp_act; // active compare value

  logic gate_buf_q; // software gate buffer
  logic gate_buf_d;
  logic gate_flag_q; // read-only gate flag
  logic gate_flag_d;
  logic remote_sel_q; // carrier versus plain high level
  logic remote_sel_d;
  logic pass_q; // carrier is passed to the pin
  logic pass_d;
  logic pin_q; // registered pin level
  logic pin_d;

  logic irq_stat_q; // sticky match status
  logic irq_stat_d;
  logic irq_mask_q; // match interrupt enable
  logic irq_mask_d;
  logic irq_q; // registered interrupt level
  logic irq_d;
  logic match_pulse_q; // one-cycle match pulse
  logic [DW-1:0] rdata_q; // read data, valid the cycle after the strobe
  logic [DW-1:0] rdata_d;

  // compare selection; the counter only runs on its own run bit, so with
  // both run bits clear it is certainly held
  always_comb begin
    cmp_act = (phase_q == cgt_pkg::CMP_FIRST) ? first_q : second_q;
    match = run_q && (cnt_q == cmp_act); // R1
  end

  // ---------------------------------------------------------------
  // counter, compare alternation and carrier clock
  // ---------------------------------------------------------------
  always_comb begin
    run_d = run_q;
    cnt_d = cnt_q;
    phase_d = phase_q;
    carrier_d = carrier_q;
    if (wr_hit(cgt_pkg::ADDR_RUN_CTRL)) begin
      run_d = i_wdata[cgt_pkg::RUN_BIT];
    end
    if (!run_q) begin
      // stopped: restart always opens with the first compare period
      cnt_d = cgt_pkg::CNT_CLEAR; // R14
      phase_d = cgt_pkg::CMP_FIRST; // R14
      carrier_d = 1'b0; // R2
    end else if (match) begin
      cnt_d = cgt_pkg::CNT_CLEAR; // R3 R4
      carrier_d = ~carrier_q; // R3 R4
      unique case (phase_q)
        cgt_pkg::CMP_FIRST: begin
          phase_d = cgt_pkg::CMP_SECOND; // R3
        end
        cgt_pkg::CMP_SECOND: begin
          phase_d = cgt_pkg::CMP_FIRST; // R4 R5
        end
      endcase
    end else begin
      cnt_d = cnt_q + 8'h01; // R2
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      run_q <= 1'b0;
      cnt_q <= cgt_pkg::CNT_CLEAR;
      phase_q <= cgt_pkg::CMP_FIRST;
      carrier_q <= 1'b0;
    end else begin
      run_q <= run_d;
      cnt_q <= cnt_d;
      phase_q <= phase_d;
      carrier_q <= carrier_d;
    end
  end

  // ---------------------------------------------------------------
  // compare registers
  // ---------------------------------------------------------------
  // the first compare may only change while stopped, since a change
  // mid-period could skip the match and run the counter round
  always_comb begin
    first_d = first_q;
    second_d = second_q;
    pend_val_d = pend_val_q;
    pend_d = pend_q;
    if (wr_hit(cgt_pkg::ADDR_FIRST_CMP) && !run_q) begin
      first_d = i_wdata;
    end
    if (!run_q) begin
      // a value left waiting at stop is applied at once
      if (pend_q) begin
        second_d = pend_val_q;
        pend_d = 1'b0;
      end
      if (wr_hit(cgt_pkg::ADDR_SECOND_CMP)) begin
        second_d = i_wdata;
        pend_d = 1'b0;
      end
    end else if (match && (phase_q == cgt_pkg::CMP_SECOND)) begin
      // transfer on the old value's match; a colliding write is dropped
      if (pend_q) begin
        second_d = pend_val_q; // R12
        pend_d = 1'b0; // R12
      end
    end else if (wr_hit(cgt_pkg::ADDR_SECOND_CMP)) begin
      pend_val_d = i_wdata; // R12
      pend_d = 1'b1; // R12
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      first_q <= cgt_pkg::RST_BYTE;
      second_q <= cgt_pkg::RST_BYTE;
      pend_val_q <= cgt_pkg::RST_BYTE;
      pend_q <= 1'b0;
    end else begin
      first_q <= first_d;
      second_q <= second_d; // R13
      pend_val_q <= pend_val_d;
      pend_q <= pend_d;
    end
  end

  // ---------------------------------------------------------------
  // gating and pin output
  // ---------------------------------------------------------------
  always_comb begin
    gate_buf_d = gate_buf_q;
    remote_sel_d = remote_sel_q;
    gate_flag_d = gate_flag_q;
    pass_d = pass_q;
    if (wr_hit(cgt_pkg::ADDR_CARRIER_CTRL)) begin
      // the flag bit of the written byte is ignored
      gate_buf_d = i_wdata[cgt_pkg::GATE_BUF_BIT]; // R11
      remote_sel_d = i_wdata[cgt_pkg::REMOTE_SEL_BIT];
    end
    // the gating event only moves the buffer into the flag
    if (sif.gate_evt && i_event_timer_run) begin
      gate_flag_d = gate_buf_q; // R6 R9
    end
    if (gate_flag_q && remote_sel_q) begin
      // start only on a rising carrier edge
      if (match && !carrier_q) begin
        pass_d = 1'b1; // R7
      end
    end else if (pass_q && (!carrier_q || !run_q || (match && carrier_q))) begin
      // never cut a high pulse short unless the run bit clears
      pass_d = 1'b0; // R8
    end
    if (remote_sel_q) begin
      pin_d = pass_d & carrier_d; // R10
    end else begin
      pin_d = gate_flag_d; // R10 R11
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gate_buf_q <= 1'b0;
      gate_flag_q <= 1'b0;
      remote_sel_q <= 1'b0;
      pass_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      gate_buf_q <= gate_buf_d;
      gate_flag_q <= gate_flag_d;
      remote_sel_q <= remote_sel_d;
      pass_q <= pass_d;
      pin_q <= pin_d;
    end
  end

  // ---------------------------------------------------------------
  // interrupt: sticky status, write one to clear, set beats clear
  // ---------------------------------------------------------------
  always_comb begin
    irq_stat_d = irq_stat_q;
    irq_mask_d = irq_mask_q;
    if (wr_hit(cgt_pkg::ADDR_IRQ_STATUS) && i_wdata[cgt_pkg::IRQ_MATCH_BIT]) begin
      irq_stat_d = 1'b0;
    end
    if (match) begin
      irq_stat_d = 1'b1; // R3 R4
    end
    if (wr_hit(cgt_pkg::ADDR_IRQ_MASK)) begin
      irq_mask_d = i_wdata[cgt_pkg::IRQ_MATCH_BIT];
    end
    irq_d = irq_stat_d & irq_mask_d;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_stat_q <= 1'b0;
      irq_mask_q <= 1'b0;
      irq_q <= 1'b0;
      match_pulse_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= irq_d;
      match_pulse_q <= match; // R3 R4
    end
  end

  // ---------------------------------------------------------------
  // read port: data stands the cycle after the strobe, else zero
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = '0;
    if (i_rd) begin
      unique case (i_addr)
        cgt_pkg::ADDR_RUN_CTRL: begin
          rdata_d[cgt_pkg::RUN_BIT] = run_q;
        end
        cgt_pkg::ADDR_FIRST_CMP: begin
          rdata_d = first_q;
        end
        cgt_pkg::ADDR_SECOND_CMP: begin
          rdata_d = pend_q ? pend_val_q : second_q;
        end
        cgt_pkg::ADDR_CARRIER_CTRL: begin
          rdata_d[cgt_pkg::GATE_FLAG_BIT] = gate_flag_q; // R11
          rdata_d[cgt_pkg::GATE_BUF_BIT] = gate_buf_q;
          rdata_d[cgt_pkg::REMOTE_SEL_BIT] = remote_sel_q;
        end
        cgt_pkg::ADDR_IRQ_STATUS: begin
          rdata_d[cgt_pkg::IRQ_MATCH_BIT] = irq_stat_q;
        end
        cgt_pkg::ADDR_IRQ_MASK: begin
          rdata_d[cgt_pkg::IRQ_MATCH_BIT] = irq_mask_q;
        end
        cgt_pkg::ADDR_COUNT: begin
          rdata_d = cnt_q;
        end
        default: begin
          rdata_d = '0; // unmapped offset reads zero
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // outputs, all from flip-flops
  assign o_rdata = rdata_q;
  assign o_carrier_output_pin = pin_q;
  assign o_carrier_match_irq = match_pulse_q;
  assign o_irq = irq_q;

endmodule

// ### bench/cgt_evt_model.sv
// companion event timer model: run level and stretched match pulse
`timescale 1ns/100ps
module cgt_evt_model (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // bench commands
  input wire logic i_run,
  input wire logic i_fire,
  // toward the carrier timer
  output logic o_run,
  output logic o_match
);
  logic [2:0] hold_q; // cycles left of the match level
  assign o_run = i_run;
  // match lasts several cycles, so only its rising edge may count
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hold_q <= 3'h0;
    end else if (i_fire) begin
      hold_q <= 3'h6;
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
    end
  end
  // skewed off the clock edge, as an unrelated source would be
  assign #3 o_match = (hold_q != 3'h0);
endmodule

// ### bench/cgt_top_sva.sv
// port timing checks of the carrier generator timer
`timescale 1ns/100ps
module cgt_top_chk (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // register port
  input wire logic [cgt_pkg::ADDR_W-1:0] i_addr,
  input wire logic [cgt_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [cgt_pkg::DATA_W-1:0] o_rdata,
  // companion and outputs
  input wire logic i_event_timer_run,
  input wire logic i_event_timer_match,
  input wire logic o_carrier_output_pin,
  input wire logic o_carrier_match_irq,
  input wire logic o_irq
);
  logic run_q; // shadow of the run bit
  logic mask_q; // shadow of the mask bit
  logic sel_q; // shadow of the pulse select
  logic clr_w; // write that may lower the interrupt
  assign clr_w = i_wr && (i_addr == cgt_pkg::ADDR_IRQ_STATUS ||
    i_addr == cgt_pkg::ADDR_IRQ_MASK);
  // shadows follow software writes, so no view inside is needed
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      run_q <= 1'b0;
      mask_q <= 1'b0;
      sel_q <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == cgt_pkg::ADDR_RUN_CTRL) run_q <= i_wdata[0];
      if (i_addr == cgt_pkg::ADDR_IRQ_MASK) mask_q <= i_wdata[0];
      if (i_addr == cgt_pkg::ADDR_CARRIER_CTRL) sel_q <= i_wdata[2];
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  chk_read_idle_zero: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_count_stopped: assert property (i_rd && i_addr == cgt_pkg::ADDR_COUNT && !run_q &&
    !$past(run_q) |=> o_rdata == 8'h00) else $error("count moved while stopped");
  chk_stop_no_irq: assert property (!run_q [*3] |-> !o_carrier_match_irq)
    else $error("match pulse while stopped");
  chk_irq_masked_in: assert property (o_carrier_match_irq && mask_q |-> o_irq)
    else $error("unmasked match did not raise irq");
  chk_irq_needs_mask: assert property (o_irq |-> mask_q)
    else $error("irq high while masked");
  chk_irq_fall_cause: assert property ($fell(o_irq) |-> $past(clr_w) || $past(clr_w, 2))
    else $error("irq fell without clear or mask");
  chk_pin_rise_edge: assert property ($rose(o_carrier_output_pin) && sel_q
    |-> o_carrier_match_irq) else $error("pulse began off a carrier rise");
  chk_pin_hold_high: assert property ($fell(o_carrier_output_pin) && sel_q && run_q &&
    $past(run_q, 2) |-> o_carrier_match_irq) else $error("pulse cut short");
  cover property (o_carrier_match_irq);
  cover property ($rose(o_carrier_output_pin) && sel_q);
  cover property ($fell(o_irq));
endmodule
bind cgt_top cgt_top_chk u_cgt_top_chk (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_event_timer_run(i_event_timer_run), .i_event_timer_match(i_event_timer_match),
  .o_carrier_output_pin(o_carrier_output_pin), .o_carrier_match_irq(o_carrier_match_irq),
  .o_irq(o_irq));

// ### bench/cgt_top_tb.sv
// self-checking bench of the carrier generator timer
`timescale 1ns/100ps
module cgt_top_tb;
  localparam logic [2:0] A_RUN = cgt_pkg::ADDR_RUN_CTRL; // short aliases
  localparam logic [2:0] A_C1 = cgt_pkg::ADDR_FIRST_CMP;
  localparam logic [2:0] A_C2 = cgt_pkg::ADDR_SECOND_CMP;
  localparam logic [2:0] A_CTL = cgt_pkg::ADDR_CARRIER_CTRL;
  localparam logic [2:0] A_ST = cgt_pkg::ADDR_IRQ_STATUS;
  localparam logic [2:0] A_MSK = cgt_pkg::ADDR_IRQ_MASK;
  logic mclk; // 100 MHz
  logic rst_b;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic erun; // companion run request
  logic fire; // companion match request
  logic ev_run;
  logic ev_match;
  logic pin;
  logic mirq;
  logic irq;
  logic [7:0] r;
  logic sel;
  logic bf;
  int errors;
  int n_tests;
  int i;
  cgt_top u_cgt_top (.i_mclk(mclk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_event_timer_run(ev_run),
    .i_event_timer_match(ev_match), .o_carrier_output_pin(pin), .o_carrier_match_irq(mirq),
    .o_irq(irq));
  cgt_evt_model u_cgt_evt_model (.i_mclk(mclk), .i_rst_b(rst_b), .i_run(erun), .i_fire(fire),
    .o_run(ev_run), .o_match(ev_match));
  // free-running clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task final_report;
    if (errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr8(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task rd8(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 cmp8(rdata, e);
  endtask
  task fire_evt;
    @(posedge mclk);
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
  endtask
  // cycles up to the next match pulse; zero skips the compare
  task gap(input logic [7:0] e);
    logic [7:0] n;
    n = 8'h00;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (mirq !== 1'b1 && n < 8'h40);
    if (e != 8'h00) cmp8(n, e);
  endtask
  // rising edges of the pin over n cycles
  task watch(input int n, output logic [7:0] c);
    logic p;
    c = 8'h00;
    // step off the edge so the starting level is the settled one
    #1 p = pin;
    repeat (n) begin
      @(posedge mclk);
      #1 if (pin === 1'b1 && p === 1'b0) c++;
      p = pin;
    end
  endtask
  // main sequence
  initial begin
    rst_b = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    erun = 1'b0;
    fire = 1'b0;
    errors = 0;
    n_tests = 0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    for (i = 0; i < 8; i++) rd8(i[2:0], 8'h00);
    wr8(A_CTL, 8'h01);
    rd8(A_CTL, 8'h00);
    rd8(cgt_pkg::ADDR_COUNT, 8'h00);
    // companion running, so the gating event is really taken in
    erun <= 1'b1;
    fire_evt;
    repeat (10) @(posedge mclk);
    rd8(A_ST, 8'h00);
    wr8(A_C1, 8'h06);
    wr8(A_C2, 8'h04);
    wr8(A_MSK, 8'h01);
    wr8(A_RUN, 8'h01);
    gap(8'h07);
    gap(8'h05);
    gap(8'h07);
    gap(8'h05);
    wr8(A_C2, 8'h01);
    gap(8'h00);
    gap(8'h05);
    gap(8'h07);
    gap(8'h02);
    cmp8({7'h00, irq}, 8'h01);
    // land a second compare write on the edge of the next second match
    repeat (7) @(posedge mclk);
    wr8(A_C2, 8'h03);
    rd8(A_C2, 8'h01);
    wr8(A_RUN, 8'h00);
    repeat (3) @(posedge mclk);
    rd8(cgt_pkg::ADDR_COUNT, 8'h00);
    wr8(A_MSK, 8'h00);
    @(posedge mclk);
    #1 cmp8({7'h00, irq}, 8'h00);
    rd8(A_ST, 8'h01);
    wr8(A_ST, 8'h01);
    rd8(A_ST, 8'h00);
    wr8(A_MSK, 8'h01);
    wr8(A_RUN, 8'h01);
    gap(8'h07);
    gap(8'h02);
    // gate modes: the order keeps the flag from leaking into the next mode
    for (i = 0; i < 4; i++) begin
      sel = i[0];
      bf = i[1];
      wr8(A_RUN, 8'h00);
      wr8(A_CTL, {5'h00, sel, bf, 1'b0});
      wr8(A_RUN, 8'h01);
      fire_evt;
      watch(40, r);
      if (!bf) cmp8(r, 8'h00);
      else if (!sel) cmp8(r, 8'h01);
      else cmp8({7'h00, r > 8'h01}, 8'h01);
      rd8(A_CTL, {5'h00, sel, bf, bf});
    end
    wr8(A_CTL, 8'h04);
    fire_evt;
    watch(30, r);
    cmp8({7'h00, pin}, 8'h00);
    final_report;
  end
  // cut a hang short
  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    final_report;
  end
endmodule
